// ===== bench/sptm_ctrl_model.sv
// memory controller model issuing mode register commands and pin levels
// assumes the bench calls its tasks; everything changes on falling edges
module sptm_ctrl_model
    import sptm_pkg::*;
(
    // clock
    input  wire logic       clk,
    // command outputs
    output logic            mrw_valid,
    output logic      [5:0] mrw_addr,
    output logic      [7:0] mrw_data,
    output logic            mrr_valid,
    output logic      [5:0] mrr_addr,
    output logic            cke,
    output logic      [5:0] ca,
    output logic            masked_write_cmd,
    // read return
    input  wire logic [7:0] dq_out,
    input  wire logic       mrr_done
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // idle levels at time zero
    // ****************************************
    initial
    begin
        {mrw_valid, mrr_valid, masked_write_cmd} = 3'b000;
        {mrw_addr, mrr_addr, mrw_data, ca} = '0;
        cke = 1'b1;
    end

    // one write command; released address and data flip so stale values never match
    task automatic mrw(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        {mrw_valid, mrw_addr, mrw_data} = {1'b1, a, d};
        @(negedge clk);
        {mrw_valid, mrw_addr, mrw_data} = {1'b0, ~a, ~d};
    endtask : mrw

    // one read command; the answer stands for the one cycle after the taking
    // edge, so it is picked up at the next falling edge before release
    task automatic mrr(input logic [5:0] a, output logic [7:0] d, output logic done);
        @(negedge clk);
        {mrr_valid, mrr_addr} = {1'b1, a};
        @(negedge clk);
        {d, done} = {dq_out, mrr_done};
        {mrr_valid, mrr_addr} = {1'b0, ~a};
    endtask : mrr

    // clock enable and command pins, called by the bench on a falling edge
    task automatic drive_pins(input logic k, input logic [5:0] c);
        {cke, ca} = {k, c};
    endtask : drive_pins

    // leave training: clock enable back high before the clearing write
    task automatic exit_training(input logic [7:0] d);
        @(negedge clk);
        cke = 1'b1;
        mrw(MR_ADDR_CTRL, d);
    endtask : exit_training

    // masked write pulse, issued only where the bench tests the illegal flag
    task automatic masked_wr();
        @(negedge clk);
        masked_write_cmd = 1'b1;
        @(negedge clk);
        masked_write_cmd = 1'b0;
    endtask : masked_wr
endmodule : sptm_ctrl_model

// ===== bench/sptm_regs_top_tb_top.sv
// self-checking bench for the set point and training register logic
// assumes the controller model drives commands; status inputs come from here
module sptm_regs_top_tb_top
    import sptm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // signals
    // ****************************************
    logic        clk, rst_b, mrw_valid, mrr_valid, cke, masked_write_cmd;
    logic [5:0]  mrw_addr, mrr_addr, ca;
    logic [7:0]  mrw_data, dq_out, rd, cur;
    logic        feature_rro_valid, dq_oe, mrr_done, done;
    logic        command_bus_training, read_preamble_training, reference_level_output;
    logic        reference_fast_settle, write_mask_enable, masked_write_illegal;
    logic [6:0]  active_ca_ref, active_dq_ref;
    logic [2:0]  refresh_raw_code, refresh_status_code;
    logic [7:0]  mode_v;    // packed view of the mode outputs
    logic [31:0] seed;      // xorshift state
    int          n_errors, samples_checked;

    assign mode_v = {dq_oe, mrr_done, command_bus_training, read_preamble_training,
                     reference_level_output, reference_fast_settle, write_mask_enable,
                     masked_write_illegal};

    // 20 MHz memory clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    sptm_ctrl_model m (.clk(clk), .mrw_valid(mrw_valid), .mrw_addr(mrw_addr),
        .mrw_data(mrw_data), .mrr_valid(mrr_valid), .mrr_addr(mrr_addr), .cke(cke),
        .ca(ca), .masked_write_cmd(masked_write_cmd), .dq_out(dq_out), .mrr_done(mrr_done));

    sptm_regs_top dut_u (.clk(clk), .rst_b(rst_b), .mrw_valid(mrw_valid),
        .mrw_addr(mrw_addr), .mrw_data(mrw_data), .mrr_valid(mrr_valid),
        .mrr_addr(mrr_addr), .cke(cke), .ca(ca), .masked_write_cmd(masked_write_cmd),
        .feature_rro_valid(feature_rro_valid), .refresh_raw_code(refresh_raw_code),
        .dq_out(dq_out), .dq_oe(dq_oe), .mrr_done(mrr_done),
        .command_bus_training(command_bus_training),
        .read_preamble_training(read_preamble_training),
        .reference_level_output(reference_level_output),
        .reference_fast_settle(reference_fast_settle),
        .write_mask_enable(write_mask_enable), .masked_write_illegal(masked_write_illegal),
        .active_ca_ref(active_ca_ref), .active_dq_ref(active_dq_ref),
        .refresh_status_code(refresh_status_code));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // mode outputs expected from a control value, no read or pulse pending
    function automatic logic [7:0] exp_mode(input logic [7:0] c);
        return {2'b00, c[0], c[1], c[2], c[3], ~c[5], 1'b0};
    endfunction : exp_mode

    // refresh code after the option filter
    function automatic logic [2:0] exp_rr(input logic f, o, input logic [2:0] r);
        if (f && !o && (r == RR_CODE_A || r == RR_CODE_B))
            return RR_CODE_SUBST;
        return r;
    endfunction : exp_rr

    task automatic chk(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // read back through the model and compare data and done flag
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        m.mrr(a, rd, done);
        chk({done, 7'h00}, 8'h80);
        chk(rd, e);
    endtask : rdchk

    task automatic wait2();
        repeat (2) @(negedge clk);
    endtask : wait2

    task automatic summarize();
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // ****************************************
    // watchdog: the sequence needs well under 1000 cycles
    // ****************************************
    initial
    begin
        #(50 * 5000);
        n_errors++;
        summarize();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rst_b, feature_rro_valid, refresh_raw_code} = 5'h00;
        {n_errors, samples_checked} = 0;
        seed = 32'h0000_53bc;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        chk(mode_v, 8'h02);
        chk({1'b0, active_ca_ref}, 8'h4d);
        rdchk(MR_ADDR_CA_REF, 8'h4d);
        rdchk(MR_ADDR_CTRL, 8'h00);
        // legal step codes with the top code first, random range and stray bit7
        for (int i = 0; i < 5; i++)
        begin
            seed = xs(seed);
            cur = {1'b0, seed[6], (i == 0) ? 6'h32 : 6'(seed[13:8] % 51)};
            m.mrw(MR_ADDR_CA_REF, cur | {seed[7], 7'h00});
            rdchk(MR_ADDR_CA_REF, cur);
            chk({1'b0, active_ca_ref}, cur);
        end
        // reserved codes are dropped whole
        seed = xs(seed);
        m.mrw(MR_ADDR_CA_REF, {2'b01, 6'h33 + 6'(seed[3:0] % 13)});
        rdchk(MR_ADDR_CA_REF, cur);
        // data-bus copy 0 gets the other range so the two copies differ
        m.mrw(MR_ADDR_DQ_REF, cur ^ 8'h40);
        rdchk(MR_ADDR_DQ_REF, cur ^ 8'h40);
        chk({1'b0, active_dq_ref}, cur ^ 8'h40);
        // second copy written while copy 0 stays in use
        m.mrw(MR_ADDR_CTRL, 8'h40);
        wait2();
        m.mrw(MR_ADDR_CA_REF, cur ^ 8'h40);
        wait2();
        chk({1'b0, active_ca_ref}, cur);
        rdchk(MR_ADDR_CA_REF, cur ^ 8'h40);
        m.mrw(MR_ADDR_CTRL, 8'h00);
        wait2();
        rdchk(MR_ADDR_CA_REF, cur);
        m.mrw(MR_ADDR_CTRL, 8'h80);
        wait2();
        chk({1'b0, active_ca_ref}, cur ^ 8'h40);
        chk({1'b0, active_dq_ref}, 8'h4d);
        // mode bits 1 to 5 each alone, then a masked write under it
        for (int i = 1; i < 6; i++)
        begin
            m.mrw(MR_ADDR_CTRL, 8'h01 << i);
            wait2();
            chk(mode_v, exp_mode(8'h01 << i));
            m.masked_wr();
            chk({7'h00, masked_write_illegal}, {7'h00, i == 5});
        end
        // training: clock enable low reflects the command pins, commands ignored
        m.mrw(MR_ADDR_CTRL, 8'h01);
        wait2();
        chk(mode_v, exp_mode(8'h01));
        for (int i = 0; i < 4; i++)
        begin
            seed = xs(seed);
            m.drive_pins(1'b0, seed[5:0]);
            @(negedge clk);
            chk({dq_oe, 1'b0, dq_out[5:0]}, {2'b10, seed[5:0]});
            chk({6'h00, dq_out[7:6]}, 8'h00);
        end
        m.mrw(MR_ADDR_CTRL, 8'h20);
        wait2();
        chk({7'h00, write_mask_enable}, 8'h01);
        m.exit_training(8'h00);
        wait2();
        chk(mode_v, exp_mode(8'h00));
        // refresh filter over feature bit, option bit and every raw code
        for (int k = 0; k < 32; k++)
        begin
            if (k % 8 == 0)
            begin
                m.mrw(MR_ADDR_CTRL, {3'b000, k[3], 4'h0});
                wait2();
            end
            {feature_rro_valid, refresh_raw_code} = {k[4], k[2:0]};
            @(negedge clk);
            chk({5'h00, refresh_status_code}, {5'h00, exp_rr(k[4], k[3], k[2:0])});
            rdchk(MR_ADDR_REFRESH, {5'h00, exp_rr(k[4], k[3], k[2:0])});
        end
        summarize();
    end
endmodule : sptm_regs_top_tb_top

// ===== verilog/sptm_pkg.sv
// constants shared by the set point and training mode register logic
// assumes one memory clock and a synchronous active-low device reset
package sptm_pkg;

    // ****************************************
    // mode register addresses
    // ****************************************
    localparam logic [5:0] MR_ADDR_REFRESH = 6'h04;  // refresh_status_reg
    localparam logic [5:0] MR_ADDR_CA_REF  = 6'h0C;  // command_bus_reference_reg
    localparam logic [5:0] MR_ADDR_CTRL    = 6'h0D;  // set_point_training_control_reg
    localparam logic [5:0] MR_ADDR_DQ_REF  = 6'h0E;  // data-bus reference register

    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_CBT_BIT  = 0;  // command_bus_training
    localparam int CTRL_RPT_BIT  = 1;  // read_preamble_training
    localparam int CTRL_VRO_BIT  = 2;  // reference_level_output
    localparam int CTRL_REFERENCE_FAST_SETTLE_BIT = 3;  // reference_fast_settle
    localparam int CTRL_RRO_BIT  = 4;  // refresh_rate_code_option
    localparam int CTRL_DMD_BIT  = 5;  // write_mask_disable
    localparam int CTRL_WR_BIT   = 6;  // set_point_access_select
    localparam int CTRL_OP_BIT   = 7;  // set_point_operate_select
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ****************************************
    // reference register fields
    // ****************************************
    localparam int         REF_RANGE_BIT = 6;      // range select bit
    localparam logic [5:0] REF_CODE_MAX  = 6'h32;  // last legal step code
    localparam logic [6:0] REF_RESET     = 7'h4D;  // range 1, code 0x0d
    localparam logic [7:0] RD_ZERO       = 8'h00;  // unmapped read data

    // ****************************************
    // refresh status codes
    // ****************************************
    localparam logic [2:0] RR_CODE_A     = 3'h1;
    localparam logic [2:0] RR_CODE_B     = 3'h2;
    localparam logic [2:0] RR_CODE_SUBST = 3'h3;

endpackage : sptm_pkg

// ===== verilog/sptm_regs_top.sv
// set point and training mode register logic of a low-power memory device
// assumes mode register commands are already decoded into strobes
// Functional notes
// - step codes up to 0x32 legal, above reserved
// - bit six of reference selects range
// - two independent set point copies kept
// - control bit0 enables command bus training
// - training with low CKE reflects CA onto DQ
// - control bit1 enables read preamble training
// - bit2 drives reference_level_output only; DQ never carries the active references
// - bit3 selects fast settle reference mode
// - bit4 low suppresses refresh codes one, two
// - option matters only when feature bit set
// - suppressed codes reported as code three
// - bit5 low enables write masking
// - bit6 picks copy for access
// - bit7 picks copy in operation
// - inactive copy ignored and freely rewritable
// - reference read returns seven bits, refresh read the status code, zeros elsewhere
module sptm_regs_top
    import sptm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // mode register write command
    input  wire logic        mrw_valid,
    input  wire logic [5:0]  mrw_addr,
    input  wire logic [7:0]  mrw_data,
    // mode register read command
    input  wire logic        mrr_valid,
    input  wire logic [5:0]  mrr_addr,
    // command bus pins
    input  wire logic        cke,
    input  wire logic [5:0]  ca,
    input  wire logic        masked_write_cmd,
    // device status inputs
    input  wire logic        feature_rro_valid,
    input  wire logic [2:0]  refresh_raw_code,
    // data bus
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    output logic             mrr_done,
    // mode outputs
    output logic             command_bus_training,
    output logic             read_preamble_training,
    output logic             reference_level_output,
    output logic             reference_fast_settle,
    output logic             write_mask_enable,
    output logic             masked_write_illegal,
    // active references and refresh status
    output logic      [6:0]  active_ca_ref,
    output logic      [6:0]  active_dq_ref,
    output logic      [2:0]  refresh_status_code
);

    // ****************************************
    // declarations
    // ****************************************
    sptm_sp_if  sp ();          // link to the set point store
    logic [7:0] ctrl_reg;       // set_point_training_control_reg
    logic       cmd_blocked;    // training with CKE low
    logic       wr_ok;          // write accepted
    logic       rd_ok;          // read accepted
    logic [7:0] rd_data;        // read mux result
    logic [2:0] refresh_next;   // filtered refresh code

    // training with CKE low swallows every mode register read and write; the controller must
    // raise CKE before it may clear the training bit
    assign cmd_blocked = ctrl_reg[CTRL_CBT_BIT] && !cke;
    assign wr_ok       = mrw_valid && !cmd_blocked;
    assign rd_ok       = mrr_valid && !cmd_blocked;

    // ****************************************
    // set point store
    // ****************************************
    assign sp.wr_en       = wr_ok && ((mrw_addr == MR_ADDR_CA_REF) ||
                                      (mrw_addr == MR_ADDR_DQ_REF));
    assign sp.wr_is_dq    = (mrw_addr == MR_ADDR_DQ_REF);
    assign sp.wr_data     = mrw_data[6:0];
    assign sp.access_fsp  = ctrl_reg[CTRL_WR_BIT];
    assign sp.operate_fsp = ctrl_reg[CTRL_OP_BIT];

    sptm_set_point_store u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .sp    (sp.store)
    );

    // ****************************************
    // control register
    // ****************************************
    // write-only; every field defaults to zero
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            ctrl_reg <= CTRL_RESET;
        else if (wr_ok && (mrw_addr == MR_ADDR_CTRL))
            ctrl_reg <= mrw_data;
    end

    // ****************************************
    // refresh status filter
    // ****************************************
    // substitution only when the feature bit says the option exists
    always_comb
    begin
        refresh_next = refresh_raw_code;
        if (feature_rro_valid && !ctrl_reg[CTRL_RRO_BIT] &&
            ((refresh_raw_code == RR_CODE_A) || (refresh_raw_code == RR_CODE_B)))
            refresh_next = RR_CODE_SUBST;
    end

    // ****************************************
    // read mux
    // ****************************************
    // control register is write-only and reads as zero
    always_comb
    begin
        if (mrr_addr == MR_ADDR_CA_REF)
            rd_data = {1'b0, sp.rd_ca};
        else if (mrr_addr == MR_ADDR_DQ_REF)
            rd_data = {1'b0, sp.rd_dq};
        else if (mrr_addr == MR_ADDR_REFRESH)
            rd_data = {5'b0_0000, refresh_next};
        else
            rd_data = RD_ZERO;
    end

    // ****************************************
    // data bus driver
    // ****************************************
    // reflection has priority: reads cannot be taken while it runs
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            dq_out   <= RD_ZERO;
            dq_oe    <= 1'b0;
            mrr_done <= 1'b0;
        end
        else if (cmd_blocked)
        begin
            dq_out   <= {2'b00, ca};
            dq_oe    <= 1'b1;
            mrr_done <= 1'b0;
        end
        else if (rd_ok)
        begin
            dq_out   <= rd_data;
            dq_oe    <= 1'b1;
            mrr_done <= 1'b1;
        end
        else
        begin
            dq_out   <= RD_ZERO;
            dq_oe    <= 1'b0;
            mrr_done <= 1'b0;
        end
    end

    // ****************************************
    // mode outputs
    // ****************************************
    // registered copies so every port leaves from a flop
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            command_bus_training   <= 1'b0;
            read_preamble_training <= 1'b0;
            reference_level_output <= 1'b0;
            reference_fast_settle  <= 1'b0;
            write_mask_enable      <= 1'b1;
        end
        else
        begin
            command_bus_training   <= ctrl_reg[CTRL_CBT_BIT];
            read_preamble_training <= ctrl_reg[CTRL_RPT_BIT];
            reference_level_output <= ctrl_reg[CTRL_VRO_BIT];
            reference_fast_settle  <= ctrl_reg[CTRL_REFERENCE_FAST_SETTLE_BIT];
            write_mask_enable      <= !ctrl_reg[CTRL_DMD_BIT];
        end
    end

    // masked write while masking is off is flagged, not executed
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            masked_write_illegal <= 1'b0;
        else
            masked_write_illegal <= masked_write_cmd && ctrl_reg[CTRL_DMD_BIT];
    end

    // ****************************************
    // active references and refresh status
    // ****************************************
    // registered every cycle whatever the output bit; dq_out never carries them
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            active_ca_ref       <= REF_RESET;
            active_dq_ref       <= REF_RESET;
            refresh_status_code <= 3'h0;
        end
        else
        begin
            active_ca_ref       <= sp.op_ca;
            active_dq_ref       <= sp.op_dq;
            refresh_status_code <= refresh_next;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_read_taken;
        mrr_valid && !cmd_blocked && (mrr_addr == MR_ADDR_CA_REF);
    endsequence

    sequence s_read_answer;
        mrr_done && dq_oe && (dq_out[7] == 1'b0);
    endsequence

    a_mrr_ca_return : assert property (
        @(posedge clk) disable iff (!rst_b)
        s_read_taken |=> s_read_answer ##0 (dq_out[6:0] == $past(sp.rd_ca)))
        else $error("reference read did not return stored value");

    a_cbt_reflect : assert property (
        @(posedge clk) disable iff (!rst_b)
        cmd_blocked |=> dq_oe && !mrr_done && (dq_out == {2'b00, $past(ca)}))
        else $error("training did not reflect command address");

    a_cbt_ignore : assert property (
        @(posedge clk) disable iff (!rst_b)
        cmd_blocked && mrw_valid |=> $stable(ctrl_reg))
        else $error("command taken while training with CKE low");

    a_cbt_enter : assert property (
        @(posedge clk) disable iff (!rst_b)
        wr_ok && (mrw_addr == MR_ADDR_CTRL) ##1 1'b1
        |=> command_bus_training == $past(mrw_data[CTRL_CBT_BIT], 2))
        else $error("training output does not follow control write");

    a_rro_subst : assert property (
        @(posedge clk) disable iff (!rst_b)
        feature_rro_valid && !ctrl_reg[CTRL_RRO_BIT] && (refresh_raw_code == RR_CODE_B)
        |=> refresh_status_code == RR_CODE_SUBST)
        else $error("suppressed refresh code was reported");

    a_rro_passthru : assert property (
        @(posedge clk) disable iff (!rst_b)
        !feature_rro_valid |=> refresh_status_code == $past(refresh_raw_code))
        else $error("refresh code changed without feature bit");

    a_mask_state : assert property (
        @(posedge clk) disable iff (!rst_b)
        ##1 (write_mask_enable == !$past(ctrl_reg[CTRL_DMD_BIT])))
        else $error("mask enable does not follow control bit");

    a_reset_default : assert property (
        @(posedge clk)
        !rst_b |=> (ctrl_reg == CTRL_RESET) && !sp.access_fsp && !sp.operate_fsp)
        else $error("control register not cleared by reset");

    a_vro_level : assert property (
        @(posedge clk) disable iff (!rst_b)
        ##1 (active_ca_ref == $past(sp.op_ca)) && (active_dq_ref == $past(sp.op_dq)))
        else $error("active reference output is stale");

endmodule : sptm_regs_top

// ===== verilog/sptm_set_point_store.sv
// two frequency set point copies of the command-bus and data-bus references
// assumes writes arrive already filtered for command blocking
module sptm_set_point_store
    import sptm_pkg::*;
(
    // clock and reset
    input wire logic  clk,
    input wire logic  rst_b,
    // control side
    sptm_sp_if.store  sp
);

    // ****************************************
    // storage
    // ****************************************
    logic [6:0] ca_ref_reg [2];  // command-bus reference per set point
    logic [6:0] dq_ref_reg [2];  // data-bus reference per set point
    logic       code_legal;      // step code inside the linear range

    // codes above the last step are reserved: such a write is dropped whole
    assign code_legal = (sp.wr_data[5:0] <= REF_CODE_MAX);

    // one pair of registers per set point
    for (genvar g = 0; g < 2; g++)
    begin : g_fsp
        // only the copy named by the access select takes the write
        always_ff @(posedge clk)
        begin
            if (!rst_b)
            begin
                ca_ref_reg[g] <= REF_RESET;
                dq_ref_reg[g] <= REF_RESET;
            end
            else if (sp.wr_en && code_legal && (sp.access_fsp == 1'(g)))
            begin
                if (sp.wr_is_dq)
                    dq_ref_reg[g] <= sp.wr_data;
                else
                    ca_ref_reg[g] <= sp.wr_data;
            end
        end
    end

    // read back follows the access copy, operation the active copy
    assign sp.rd_ca = ca_ref_reg[sp.access_fsp];
    assign sp.rd_dq = dq_ref_reg[sp.access_fsp];
    assign sp.op_ca = ca_ref_reg[sp.operate_fsp];
    assign sp.op_dq = dq_ref_reg[sp.operate_fsp];

    // ****************************************
    // checks
    // ****************************************
    a_inactive_isolated : assert property (
        @(posedge clk) disable iff (!rst_b)
        sp.wr_en && (sp.access_fsp != sp.operate_fsp)
        |=> $stable(sp.op_ca) && $stable(sp.op_dq) || $changed(sp.operate_fsp))
        else $error("inactive set point write changed the active reference");

    a_reserved_dropped : assert property (
        @(posedge clk) disable iff (!rst_b)
        sp.wr_en && (sp.wr_data[5:0] > REF_CODE_MAX)
        |=> $stable(sp.rd_ca) && $stable(sp.rd_dq) || $changed(sp.access_fsp))
        else $error("reserved reference code was stored");

endmodule : sptm_set_point_store

// ===== verilog/sptm_sp_if.sv
// carrier between the control logic and the set point store
// assumes both ends run on the same memory clock
interface sptm_sp_if;
    logic       wr_en;       // write one reference register
    logic       wr_is_dq;    // 1: data-bus reference, 0: command-bus
    logic [6:0] wr_data;     // range bit and step code
    logic       access_fsp;  // copy written and read back
    logic       operate_fsp; // copy in use
    logic [6:0] rd_ca;       // command-bus reference of the access copy
    logic [6:0] rd_dq;       // data-bus reference of the access copy
    logic [6:0] op_ca;       // command-bus reference of the active copy
    logic [6:0] op_dq;       // data-bus reference of the active copy

    modport ctrl  (output wr_en, wr_is_dq, wr_data, access_fsp, operate_fsp,
                   input rd_ca, rd_dq, op_ca, op_dq);
    modport store (input wr_en, wr_is_dq, wr_data, access_fsp, operate_fsp,
                   output rd_ca, rd_dq, op_ca, op_dq);
endinterface : sptm_sp_if
